// File: src/dual_pulse_generator_8_16.sv
// dual 8-bit / single 16-bit pulse generator with avalon-mm registers
// assumes one 100 MHz clock, synchronous reset and an avalon master
// Operation
// - independent mode: two separate channels, pins A/B
// - combined mode: 16-bit timer, both pins identical
// - prescaler mode: ch0 borrow clocks ch1
// - ch0 run bit7 starts; wide mode also needs ch1 run; stopped holds low
// - ch1 run bit7 of ctrl1 starts; wide mode also needs ch0 run; stopped holds low
// - bit5 enables pulse drive on pin A
// - bit5 of ctrl1 enables pulse drive on pin B
// - ch0 irq enable raises request on flag
// - ch1 irq enable raises request on flag
// - ch0 flag set on 8/16-bit borrow
// - writing 0 clears flag, 1 ignored
// - read-modify-write read returns flag as 1
// - mode field: 00 dual, 01 prescale, 11 wide
// - alternate reloads; output inverts on each borrow
// - phase lasts reload plus one count clocks
// - clock select: divide 1..16 or time base
`timescale 1ns/1ps
`default_nettype none
`include "pulse_gen_consts.svh"

module dual_pulse_generator_8_16 (
  // clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_rst,
  // avalon-mm slave
  input  wire logic [8:0]  i_avs_address,
  input  wire logic        i_avs_read,
  input  wire logic        i_avs_write,
  input  wire logic [31:0] i_avs_writedata,
  input  wire logic [3:0]  i_avs_byteenable,
  input  wire logic        i_rmw_read,
  output logic      [31:0] o_avs_readdata,
  output logic             o_avs_waitrequest,
  // time base count clock input
  input  wire logic        i_timebase_tick,
  // pulse pins
  output logic             o_pulse_out_a,
  output logic             o_pin_a_oe,
  output logic             o_pulse_out_b,
  output logic             o_pin_b_oe,
  // interrupts
  output logic             o_ch0_irq,
  output logic             o_ch1_irq,
  output logic             o_irq
);

  // ****************************************
  // storage
  // ****************************************
  logic                  wait_q;
  logic                  run0_q, run1_q, oe_a_q, oe_b_q, ie0_q, ie1_q;
  logic                  uf0_q, uf1_q;
  pulse_gen_pkg::mode_type mode_q;
  logic [2:0]            cs0_q, cs1_q;
  logic [7:0]            rl_q [0:3];
  logic [1:0]            stat_q, mask_q;
  logic [3:0]            pre_q;
  logic                  tb_s1_q, tb_s2_q, tb_s3_q;
  logic [7:0]            cnt0_q, cnt1_q, cnt0_d, cnt1_d;
  logic                  lvl0_q, lvl1_q, lvl0_d, lvl1_d;
  logic                  bor0, bor1, tick0, tick1, tb_tick;
  logic                  wr_en;
  logic [6:0]            idx;
  logic [7:0]            wd;
  logic [31:0]           rd_d;

  // ****************************************
  // helpers
  // ****************************************
  function automatic logic is_reg(input logic [6:0] a, input logic [6:0] r);
    return a == r;
  endfunction

  // count enable for one channel from its clock select code
  function automatic logic sel_tick(input logic [2:0] s, input logic [3:0] p,
                                    input logic tb);
    case (s)
      `PG_CS_DIV1:  sel_tick = 1'b1;
      `PG_CS_DIV2:  sel_tick = p[0];
      `PG_CS_DIV4:  sel_tick = &p[1:0];
      `PG_CS_DIV8:  sel_tick = &p[2:0];
      `PG_CS_DIV16: sel_tick = &p[3:0];
      `PG_CS_TBASE: sel_tick = tb;
      default:      sel_tick = 1'b0; // unused codes never count
    endcase
  endfunction

  // one 8-bit channel step: returns {borrow, level, count}
  function automatic logic [9:0] chan_step(input logic run, input logic tick,
                                           input logic [7:0] cnt, input logic lvl,
                                           input logic [7:0] lo, input logic [7:0] hi);
    if (!run)
      chan_step = {1'b0, 1'b0, lo}; // armed with the low width
    else if (tick && cnt == 8'h00)
      chan_step = {1'b1, ~lvl, (lvl ? lo : hi)};
    else if (tick)
      chan_step = {1'b0, lvl, cnt - 8'h01};
    else
      chan_step = {1'b0, lvl, cnt};
  endfunction

  // ****************************************
  // avalon slave
  // ****************************************
  assign idx   = i_avs_address[8:2];
  assign wd    = i_avs_writedata[7:0];
  assign wr_en = i_avs_write & ~wait_q & i_avs_byteenable[0];

  // one wait cycle, then a single low cycle that completes the access
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
      wait_q <= 1'b1;
    else if ((i_avs_read | i_avs_write) && wait_q)
      wait_q <= 1'b0;
    else
      wait_q <= 1'b1;
  end

  // read mux; unmapped and reserved bits read as zero, except control bit0 which reads as one
  always_comb
  begin
    rd_d = 32'h0000_0000;
    if (is_reg(idx, `PG_IDX_CTRL0))
      rd_d[7:0] = {run0_q, 1'b0, oe_a_q, ie0_q, uf0_q | i_rmw_read,
                   2'b00, 1'b1};
    else if (is_reg(idx, `PG_IDX_CTRL1))
      rd_d[7:0] = {run1_q, 1'b0, oe_b_q, ie1_q, uf1_q | i_rmw_read,
                   mode_q, 1'b1};
    else if (is_reg(idx, `PG_IDX_PINCLK))
      rd_d[7:0] = {cs1_q, cs0_q, 2'b00};
    else if (is_reg(idx, `PG_IDX_RL0_LO))
      rd_d[7:0] = rl_q[0];
    else if (is_reg(idx, `PG_IDX_RL0_HI))
      rd_d[7:0] = rl_q[1];
    else if (is_reg(idx, `PG_IDX_RL1_LO))
      rd_d[7:0] = rl_q[2];
    else if (is_reg(idx, `PG_IDX_RL1_HI))
      rd_d[7:0] = rl_q[3];
    else if (is_reg(idx, `PG_IDX_STAT))
      rd_d[1:0] = stat_q;
    else if (is_reg(idx, `PG_IDX_MASK))
      rd_d[1:0] = mask_q;
  end

  // data is captured as waitrequest drops, so it stands at the taking edge
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
      o_avs_readdata <= 32'h0000_0000;
    else if (i_avs_read && wait_q)
      o_avs_readdata <= rd_d;
  end

  assign o_avs_waitrequest = wait_q;

  // control bits; reserved bit0 writes are ignored
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      {run0_q, run1_q, oe_a_q, oe_b_q, ie0_q, ie1_q} <= 6'h00;
      mode_q <= pulse_gen_pkg::MODE_DUAL;
      cs0_q  <= `PG_CS_DIV1;
      cs1_q  <= `PG_CS_DIV1;
      mask_q <= 2'h0;
    end
    else if (wr_en)
    begin
      if (is_reg(idx, `PG_IDX_CTRL0))
      begin
        run0_q <= wd[`PG_B_RUN];
        oe_a_q <= wd[`PG_B_OE];
        ie0_q  <= wd[`PG_B_IE];
      end
      if (is_reg(idx, `PG_IDX_CTRL1))
      begin
        run1_q <= wd[`PG_B_RUN];
        oe_b_q <= wd[`PG_B_OE];
        ie1_q  <= wd[`PG_B_IE];
        // reserved code 10 is refused, mode stays
        if (wd[`PG_B_MD_HI:`PG_B_MD_LO] != 2'b10)
          mode_q <= pulse_gen_pkg::mode_type'(wd[`PG_B_MD_HI:`PG_B_MD_LO]);
      end
      if (is_reg(idx, `PG_IDX_PINCLK))
      begin
        cs1_q <= wd[`PG_B_CS1_HI:`PG_B_CS1_LO];
        cs0_q <= wd[`PG_B_CS0_HI:`PG_B_CS0_LO];
      end
      if (is_reg(idx, `PG_IDX_MASK))
        mask_q <= wd[1:0];
    end
  end

  // reload values, software only
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      for (int i = 0; i < 4; i++)
        rl_q[i] <= 8'h00;
    end
    else if (wr_en && idx[6:2] == 5'(`PG_IDX_RL0_LO >> 2))
      rl_q[idx[1:0]] <= wd;
  end

  // ****************************************
  // count clocks
  // ****************************************
  // free divider; only the first flop of the sync feeds the second
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      pre_q <= 4'h0;
      {tb_s1_q, tb_s2_q, tb_s3_q} <= 3'h0;
    end
    else
    begin
      pre_q <= pre_q + 4'h1;
      {tb_s1_q, tb_s2_q, tb_s3_q} <= {i_timebase_tick, tb_s1_q, tb_s2_q};
    end
  end

  assign tb_tick = tb_s2_q & ~tb_s3_q; // rising edge of the time base
  assign tick0   = sel_tick(cs0_q, pre_q, tb_tick);

  // ****************************************
  // counters
  // ****************************************
  // one process for both channels because wide mode joins them
  always_comb
  begin
    {bor0, lvl0_d, cnt0_d} = chan_step(run0_q, tick0, cnt0_q, lvl0_q, rl_q[0], rl_q[1]);
    // prescaler mode clocks ch1 by ch0 borrow
    tick1 = (mode_q == pulse_gen_pkg::MODE_PRESCALE) ? bor0
                                                     : sel_tick(cs1_q, pre_q, tb_tick);
    {bor1, lvl1_d, cnt1_d} = chan_step(run1_q, tick1, cnt1_q, lvl1_q, rl_q[2], rl_q[3]);
    if (mode_q == pulse_gen_pkg::MODE_WIDE)
    begin
      bor0 = 1'b0;
      bor1 = 1'b0;
      if (!(run0_q && run1_q))
      begin
        {cnt1_d, cnt0_d} = {rl_q[2], rl_q[0]};
        lvl0_d = 1'b0;
        lvl1_d = 1'b0;
      end
      else if (tick0 && {cnt1_q, cnt0_q} == 16'h0000)
      begin
        {cnt1_d, cnt0_d} = lvl0_q ? {rl_q[2], rl_q[0]} : {rl_q[3], rl_q[1]};
        lvl0_d = ~lvl0_q;
        lvl1_d = ~lvl0_q;
        bor0   = 1'b1;
        bor1   = 1'b1;
      end
      else
      begin
        {cnt1_d, cnt0_d} = {cnt1_q, cnt0_q} - (tick0 ? 16'h0001 : 16'h0000);
        lvl0_d = lvl0_q;
        lvl1_d = lvl0_q;
      end
    end
  end

  // counters and levels; a stopped channel idles low
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      {cnt0_q, cnt1_q} <= 16'h0000;
      {lvl0_q, lvl1_q} <= 2'b00;
    end
    else
    begin
      {cnt0_q, cnt1_q} <= {cnt0_d, cnt1_d};
      {lvl0_q, lvl1_q} <= {lvl0_d, lvl1_d};
    end
  end

  // ****************************************
  // flags and interrupts
  // ****************************************
  // a borrow beats a clearing write in the same cycle
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      {uf0_q, uf1_q} <= 2'b00;
      stat_q         <= 2'h0;
    end
    else
    begin
      if (bor0)
        uf0_q <= 1'b1;
      else if (wr_en && is_reg(idx, `PG_IDX_CTRL0) && !wd[`PG_B_UF])
        uf0_q <= 1'b0;
      if (bor1)
        uf1_q <= 1'b1;
      else if (wr_en && is_reg(idx, `PG_IDX_CTRL1) && !wd[`PG_B_UF])
        uf1_q <= 1'b0;
      stat_q <= (stat_q & ~((wr_en && is_reg(idx, `PG_IDX_STAT)) ? wd[1:0] : 2'h0))
                | {bor1, bor0};
    end
  end

  // registered pins and requests; pin levels pass whatever oe says
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      {o_pulse_out_a, o_pin_a_oe, o_pulse_out_b, o_pin_b_oe} <= 4'h0;
      {o_ch0_irq, o_ch1_irq, o_irq} <= 3'h0;
    end
    else
    begin
      o_pulse_out_a <= lvl0_q;
      o_pin_a_oe    <= oe_a_q;
      o_pulse_out_b <= lvl1_q;
      o_pin_b_oe    <= oe_b_q;
      o_ch0_irq     <= ie0_q & uf0_q;
      o_ch1_irq     <= ie1_q & uf1_q;
      o_irq         <= |(stat_q & mask_q);
    end
  end

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  stop_a_low_a: assert property (!run0_q |=> !lvl0_q)
    else $error("stopped ch0 not low");
  stop_b_low_a: assert property (!run1_q |=> !lvl1_q ##1 !o_pulse_out_b)
    else $error("stopped ch1 not low");
  pin_a_drive_a: assert property (oe_a_q && lvl0_q |=> o_pin_a_oe && o_pulse_out_a)
    else $error("pin a not driven");
  ch0_irq_raise_a: assert property ($rose(uf0_q) && ie0_q |=> o_ch0_irq)
    else $error("ch0 request missing");
  ch1_irq_gate_a: assert property (!ie1_q |=> !o_ch1_irq)
    else $error("ch1 request while disabled");
  flag_set_a: assert property (bor0 |=> uf0_q)
    else $error("ch0 flag not set");
  flag_keep_a: assert property (uf0_q && wr_en && is_reg(idx, `PG_IDX_CTRL0)
                                && wd[`PG_B_UF] |=> uf0_q)
    else $error("writing one cleared flag");
  rmw_read_a: assert property (i_avs_read && wait_q && i_rmw_read
                               && is_reg(idx, `PG_IDX_CTRL0) |=> o_avs_readdata[3])
    else $error("rmw read flag not one");
  mode_legal_a: assert property (mode_q != pulse_gen_pkg::MODE_RESV)
    else $error("reserved mode entered");
  reload_high_a: assert property (mode_q == pulse_gen_pkg::MODE_DUAL && bor0 && !lvl0_q
                                  |=> lvl0_q && cnt0_q == $past(rl_q[1]))
    else $error("high reload wrong");
  wide_same_a: assert property (mode_q == pulse_gen_pkg::MODE_WIDE
                                && $past(mode_q) == pulse_gen_pkg::MODE_WIDE
                                |-> lvl0_q == lvl1_q)
    else $error("wide pins differ");
  wait_one_a: assert property (!wait_q |=> wait_q)
    else $error("waitrequest low too long");

  cover_dual_c:  cover property (mode_q == pulse_gen_pkg::MODE_DUAL && bor0 ##1 bor1);
  cover_pre_c:   cover property (mode_q == pulse_gen_pkg::MODE_PRESCALE && bor1);
  cover_wide_c:  cover property (mode_q == pulse_gen_pkg::MODE_WIDE && bor0);
  cover_irq_c:   cover property ($rose(o_irq));

endmodule // dual_pulse_generator_8_16

`default_nettype wire

// File: include/pulse_gen_consts.svh
// register indexes, field positions and codes of the pulse generator
// assumes a 32-bit bus; byte address is four times the index
`ifndef PULSE_GEN_CONSTS_SVH
`define PULSE_GEN_CONSTS_SVH
// register indexes
`define PG_IDX_CTRL0   7'h44
`define PG_IDX_CTRL1   7'h45
`define PG_IDX_PINCLK  7'h46
`define PG_IDX_RL0_LO  7'h48
`define PG_IDX_RL0_HI  7'h49
`define PG_IDX_RL1_LO  7'h4a
`define PG_IDX_RL1_HI  7'h4b
`define PG_IDX_STAT    7'h4c
`define PG_IDX_MASK    7'h4d
// control byte fields, same places in both control registers
`define PG_B_RUN       7
`define PG_B_OE        5
`define PG_B_IE        4
`define PG_B_UF        3
`define PG_B_MD_HI     2
`define PG_B_MD_LO     1
`define PG_B_RSV       0
// pin_and_clock_control fields
`define PG_B_CS1_HI    7
`define PG_B_CS1_LO    5
`define PG_B_CS0_HI    4
`define PG_B_CS0_LO    2
// count clock select codes
`define PG_CS_DIV1     3'h0
`define PG_CS_DIV2     3'h1
`define PG_CS_DIV4     3'h2
`define PG_CS_DIV8     3'h3
`define PG_CS_DIV16    3'h4
`define PG_CS_TBASE    3'h7
`endif

// File: include/pulse_gen_pkg.sv
// types shared by the pulse generator
// assumes nothing of its surroundings
`default_nettype none
package pulse_gen_pkg;
  typedef enum logic [1:0] {
    MODE_DUAL     = 2'b00,
    MODE_PRESCALE = 2'b01,
    MODE_RESV     = 2'b10,
    MODE_WIDE     = 2'b11
  } mode_type;
endpackage

`default_nettype wire

// File: tb/pulse_monitor.sv
// far side model: measures the widths a pulse pin shows
// assumes pin and enable change on the rising edge of the block clock
`timescale 1ns/1ps
`default_nettype none

module pulse_monitor (
  // clock
  input  wire logic        i_clk,
  // pin level and its drive enable
  input  wire logic        i_pin,
  input  wire logic        i_oe,
  // last complete low and high widths, in clocks
  output logic      [15:0] o_lo_len,
  output logic      [15:0] o_hi_len
);
  logic        prev_q;
  logic [15:0] cnt_q;

  // an undriven pin is a port pin: no width is measured while oe is low
  always_ff @(posedge i_clk)
  begin
    prev_q <= i_pin;
    if (!i_oe)
    begin
      cnt_q <= 16'h0000;
    end
    else if (i_pin == prev_q)
    begin
      cnt_q <= cnt_q + 16'h0001;
    end
    else
    begin
      if (prev_q)
        o_hi_len <= cnt_q;
      else
        o_lo_len <= cnt_q;
      cnt_q <= 16'h0001; // the first partial phase is overwritten later
    end
  end
endmodule // pulse_monitor

`default_nettype wire

// File: tb/test_dual_pulse_generator_8_16.sv
// bench: register tests and pulse width checks of the pulse generator
// assumes the avalon slave answers after one wait cycle, as handed over
`timescale 1ns/1ps
`default_nettype none
`include "pulse_gen_consts.svh"

`define CHK(nm, exp, got) \
  begin \
    check_count++; \
    if ((got) !== (exp)) \
    begin \
      err_count++; \
      $display("Error %s expected %h seen %h", nm, exp, got); \
    end \
  end

module test_dual_pulse_generator_8_16;
  logic        i_clk = 1'b0;
  logic        i_rst = 1'b1;
  logic [8:0]  adr = 9'h000;
  logic        rd_en = 1'b0;
  logic        wr_en = 1'b0;
  logic [31:0] wdat = 32'h00000000;
  logic        rmw = 1'b0;
  logic        tbase = 1'b0;
  logic [31:0] rdat;
  logic        wait_rq;
  logic        pa, pa_oe, pb, pb_oe, irq0, irq1, irq;
  logic [15:0] a_lo, a_hi, b_lo, b_hi;
  int          err_count = 0;
  int          check_count = 0;
  int          cycles = 0;

  dual_pulse_generator_8_16 dut (
    .i_clk(i_clk), .i_rst(i_rst), .i_avs_address(adr), .i_avs_read(rd_en),
    .i_avs_write(wr_en), .i_avs_writedata(wdat), .i_avs_byteenable(4'hf),
    .i_rmw_read(rmw), .o_avs_readdata(rdat), .o_avs_waitrequest(wait_rq),
    .i_timebase_tick(tbase), .o_pulse_out_a(pa), .o_pin_a_oe(pa_oe),
    .o_pulse_out_b(pb), .o_pin_b_oe(pb_oe), .o_ch0_irq(irq0),
    .o_ch1_irq(irq1), .o_irq(irq));
  pulse_monitor mon_a (.i_clk(i_clk), .i_pin(pa), .i_oe(pa_oe), .o_lo_len(a_lo), .o_hi_len(a_hi));
  pulse_monitor mon_b (.i_clk(i_clk), .i_pin(pb), .i_oe(pb_oe), .o_lo_len(b_lo), .o_hi_len(b_hi));

  // ************
  // bus tasks
  // ************
  task automatic cyc(input int n);
    repeat (n) @(posedge i_clk);
  endtask

  // values read right after the edge are those sampled at that edge
  task automatic wr(input logic [6:0] idx, input logic [7:0] d);
    @(posedge i_clk);
    adr <= {idx, 2'b00};
    wdat <= {24'h000000, d};
    wr_en <= 1'b1;
    do @(posedge i_clk); while (wait_rq !== 1'b0);
    wr_en <= 1'b0;
  endtask

  task automatic rchk(input string nm, input logic [6:0] idx, input logic m,
                      input logic [7:0] exp);
    @(posedge i_clk);
    adr <= {idx, 2'b00};
    rmw <= m;
    rd_en <= 1'b1;
    do @(posedge i_clk); while (wait_rq !== 1'b0);
    `CHK(nm, {24'h000000, exp}, rdat)
    rd_en <= 1'b0;
    rmw <= 1'b0;
  endtask

  task automatic reloads(input logic [7:0] l0, h0, l1, h1);
    wr(`PG_IDX_RL0_LO, l0);
    wr(`PG_IDX_RL0_HI, h0);
    wr(`PG_IDX_RL1_LO, l1);
    wr(`PG_IDX_RL1_HI, h1);
  endtask

  task automatic widths(input logic [15:0] al, ah, bl, bh);
    cyc(300);
    `CHK("pin a low width", al, a_lo)
    `CHK("pin a high width", ah, a_hi)
    `CHK("pin b low width", bl, b_lo)
    `CHK("pin b high width", bh, b_hi)
  endtask

  task automatic conclude();
    $display("checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // ************
  // clock and timeout
  // ************
  initial
  begin
    forever #5 i_clk = ~i_clk;
  end

  // time base input: one rising edge every eight clocks
  initial
  begin
    forever
    begin
      cyc(4);
      tbase <= ~tbase;
    end
  end

  // a hang anywhere is cut short here and counted as a mismatch
  always @(posedge i_clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      err_count++;
      conclude();
    end
  end

  // ************
  // main sequence
  // ************
  initial
  begin
    cyc(20);
    i_rst <= 1'b0;
    cyc(1);
    `CHK("pulse a after reset", 1'b0, pa)
    `CHK("irq after reset", 1'b0, irq)
    `CHK("wait after reset", 1'b1, wait_rq)
    rchk("ctrl0 reset", `PG_IDX_CTRL0, 1'b0, 8'h01);
    rchk("ctrl1 reset", `PG_IDX_CTRL1, 1'b0, 8'h01);
    rchk("unmapped", 7'h47, 1'b0, 8'h00);
    // dual mode: ch0 on every clock, ch1 on every fourth clock
    reloads(8'h02, 8'h04, 8'h01, 8'h02);
    wr(`PG_IDX_PINCLK, 8'h40);
    wr(`PG_IDX_CTRL1, 8'hb1);
    wr(`PG_IDX_CTRL0, 8'hb1);
    widths(16'd3, 16'd5, 16'd8, 16'd12);
    `CHK("pin a enable", 1'b1, pa_oe)
    `CHK("pin b enable", 1'b1, pb_oe)
    `CHK("ch0 irq", 1'b1, irq0)
    `CHK("ch1 irq", 1'b1, irq1)
    rchk("ctrl0 flag", `PG_IDX_CTRL0, 1'b0, 8'hb9);
    wr(`PG_IDX_CTRL0, 8'h19);
    rchk("flag kept by 1", `PG_IDX_CTRL0, 1'b0, 8'h19);
    cyc(3);
    `CHK("pulse a stopped", 1'b0, pa)
    wr(`PG_IDX_CTRL0, 8'h11);
    cyc(3);
    `CHK("ch0 irq cleared", 1'b0, irq0)
    rchk("rmw read", `PG_IDX_CTRL0, 1'b1, 8'h19);
    wr(`PG_IDX_CTRL1, 8'h01);
    cyc(3);
    `CHK("pulse b stopped", 1'b0, pb)
    rchk("ctrl1 stopped", `PG_IDX_CTRL1, 1'b0, 8'h01);
    // status, mask and the shared interrupt
    rchk("status", `PG_IDX_STAT, 1'b0, 8'h03);
    `CHK("irq masked", 1'b0, irq)
    wr(`PG_IDX_MASK, 8'h01);
    cyc(3);
    `CHK("irq unmasked", 1'b1, irq)
    wr(`PG_IDX_STAT, 8'h03);
    cyc(3);
    `CHK("irq cleared", 1'b0, irq)
    wr(7'h47, 8'hff);
    rchk("unmapped write", 7'h47, 1'b0, 8'h00);
    wr(`PG_IDX_CTRL1, 8'h05);
    rchk("reserved mode", `PG_IDX_CTRL1, 1'b0, 8'h01);
    // wide mode: 16-bit low 0x0001, high 0x0003
    reloads(8'h01, 8'h03, 8'h00, 8'h00);
    wr(`PG_IDX_PINCLK, 8'h00);
    wr(`PG_IDX_CTRL1, 8'ha7);
    wr(`PG_IDX_CTRL0, 8'ha1);
    widths(16'd2, 16'd4, 16'd2, 16'd4);
    rchk("wide ch0 flag", `PG_IDX_CTRL0, 1'b0, 8'ha9);
    rchk("wide ch1 flag", `PG_IDX_CTRL1, 1'b0, 8'haf);
    // prescaler: ch0 borrows every 2 clocks, clocking ch1
    wr(`PG_IDX_CTRL0, 8'h01);
    wr(`PG_IDX_CTRL1, 8'h03);
    reloads(8'h01, 8'h01, 8'h01, 8'h02);
    wr(`PG_IDX_CTRL0, 8'ha1);
    wr(`PG_IDX_CTRL1, 8'ha3);
    widths(16'd2, 16'd2, 16'd4, 16'd6);
    // dual again: time base clocks ch0, divide by 8 clocks ch1
    wr(`PG_IDX_CTRL0, 8'h01);
    wr(`PG_IDX_CTRL1, 8'h01);
    reloads(8'h00, 8'h01, 8'h01, 8'h02);
    wr(`PG_IDX_PINCLK, 8'h7c);
    wr(`PG_IDX_CTRL1, 8'ha1);
    wr(`PG_IDX_CTRL0, 8'ha1);
    widths(16'd8, 16'd16, 16'd16, 16'd24);
    // reset in mid-run clears enables, flags and pins
    i_rst <= 1'b1;
    cyc(3);
    i_rst <= 1'b0;
    cyc(1);
    `CHK("pulse a after mid reset", 1'b0, pa)
    `CHK("pulse b after mid reset", 1'b0, pb)
    `CHK("pin a enable after reset", 1'b0, pa_oe)
    `CHK("pin b enable after reset", 1'b0, pb_oe)
    `CHK("wait after mid reset", 1'b1, wait_rq)
    rchk("ctrl0 after reset", `PG_IDX_CTRL0, 1'b0, 8'h01);
    rchk("ctrl1 after reset", `PG_IDX_CTRL1, 1'b0, 8'h01);
    rchk("status after reset", `PG_IDX_STAT, 1'b0, 8'h00);
    conclude();
  end
endmodule // test_dual_pulse_generator_8_16

`default_nettype wire
